/* core/nor_sync_burst_read_port.sv */
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
module nor_sync_burst_read_port
  import nor_burst_pkg::*;
#(
  parameter int ADDR_W    = ADDR_W_DEFAULT,
  parameter int MEM_AW    = MEM_AW_DEFAULT,
  parameter int MEM_DEPTH = 1 << MEM_AW_DEFAULT
) (
  // System clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // Avalon-MM register slave
  input  wire logic [BUS_AW-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Burst link pins
  input  wire logic              burstClk,
  input  wire logic              latchN,
  input  wire logic              chipSelN,
  input  wire logic              outEnN,
  input  wire logic [ADDR_W-1:0] addrIn,
  output logic      [15:0]       dataOut,
  output logic                   dataOe,
  output logic                   readyWaitOut,
  output logic                   readyWaitOe
);
  import nor_burst_pkg::*;

  // ----------------------------------------------------------------
  // Types and storage
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              waitReq;
    logic [31:0]       rdData;
    logic [2:0]        latency;
    logic              waitEarly;
    logic              falling;
    logic              waitFunc;
    logic              cfgTgl;
    logic [1:0]        ackSync;
    logic [1:0]        busySync;
    logic [2:0]        wordSync;
    logic [2:0]        latchSync;
    logic [ADDR_W-1:0] lastAddr;
    logic [MEM_AW-1:0] memAddr;
    logic [31:0]       wordCount;
    logic [31:0]       latchCount;
  } sys_s;

  sys_s              q;
  sys_s              d;
  word_t             mem [MEM_DEPTH];
  logic              memWe;
  word_t             memWrData;
  logic              burstClkEff;
  logic              cfgPending;
  logic              wordEvent;
  logic              latchEvent;
  logic              commit;
  logic [31:0]       cfgMerged;
  logic [31:0]       memMerged;
  logic [31:0]       addrMerged;

  burst_link_if #(.ADDR_W(ADDR_W), .MEM_AW(MEM_AW)) link ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] applyBe(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = newVal[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [2:0] clampLatency(input logic [2:0] val);
    return (val < LATENCY_MIN) ? LATENCY_MIN : val;
  endfunction

  function automatic logic [31:0] configWord(input sys_s s);
    logic [31:0] w;
    w                                = 32'h0000_0000;
    w[CFG_LAT_MSB:CFG_LAT_LSB]       = s.latency;
    w[CFG_WAIT_EARLY_BIT]            = s.waitEarly;
    w[CFG_FALLING_BIT]               = s.falling;
    w[CFG_WAIT_FUNC_BIT]             = s.waitFunc;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Link engine
  // ----------------------------------------------------------------
  // Active edge chosen by inverting the link clock; change only while idle
  assign burstClkEff = burstClk ^ q.falling;

  assign link.cfgLatency   = q.latency;
  assign link.cfgWaitEarly = q.waitEarly;
  assign link.cfgWaitFunc  = q.waitFunc;
  assign link.cfgTgl       = q.cfgTgl;
  assign link.latchN       = latchN;
  assign link.chipSelN     = chipSelN;
  assign link.outEnN       = outEnN;
  assign link.addrIn       = addrIn;
  // Array contents only change under software control between bursts
  assign link.rdData       = mem[link.rdAddr];

  burst_engine #(
    .ADDR_W (ADDR_W),
    .MEM_AW (MEM_AW)
  ) u_engine (
    .linkClk (burstClkEff),
    .rstReq  (sys_rst),
    .link    (link)
  );

  assign dataOut      = link.dataOut;
  assign dataOe       = link.dataOe;
  assign readyWaitOut = link.rwOut;
  assign readyWaitOe  = link.rwOe;

  // ----------------------------------------------------------------
  // Crossing status from the link domain
  // ----------------------------------------------------------------
  assign cfgPending = (q.cfgTgl != q.ackSync[1]);
  assign wordEvent  = q.wordSync[2] ^ q.wordSync[1];
  assign latchEvent = q.latchSync[2] ^ q.latchSync[1];

  // ----------------------------------------------------------------
  // Register file and bus handshake
  // ----------------------------------------------------------------
  assign commit    = (avs_read || avs_write) && !q.waitReq;
  assign memWe     = commit && avs_write && (avs_address == REG_MEM_DATA);
  assign memMerged = applyBe({16'h0000, mem[q.memAddr]}, avs_writedata, avs_byteenable);
  assign memWrData = memMerged[15:0];
  assign cfgMerged = applyBe(configWord(q), avs_writedata, avs_byteenable);
  assign addrMerged = applyBe({{(32-MEM_AW){1'b0}}, q.memAddr}, avs_writedata,
                              avs_byteenable);

  always_comb begin
    d           = q;
    d.ackSync   = {q.ackSync[0], link.cfgAck};
    d.busySync  = {q.busySync[0], link.busy};
    d.wordSync  = {q.wordSync[1:0], link.wordTgl};
    d.latchSync = {q.latchSync[1:0], link.latchTgl};

    // Latched address is stable long after its toggle is seen
    if (latchEvent) begin
      d.lastAddr   = link.lastAddr;
      d.latchCount = q.latchCount + 32'h0000_0001;
    end
    if (wordEvent) begin
      d.wordCount = q.wordCount + 32'h0000_0001;
    end

    // One wait cycle, then the answer stands for the completing edge
    if ((avs_read || avs_write) && q.waitReq) begin
      d.waitReq = 1'h0;
      unique case (avs_address)
        REG_CONFIG:      d.rdData = configWord(q);
        REG_STATUS: begin
          d.rdData                    = 32'h0000_0000;
          d.rdData[STAT_CFG_PEND_BIT] = cfgPending;
          d.rdData[STAT_BUSY_BIT]     = q.busySync[1];
        end
        REG_MEM_ADDR:    d.rdData = {{(32-MEM_AW){1'b0}}, q.memAddr};
        REG_MEM_DATA:    d.rdData = {16'h0000, mem[q.memAddr]};
        REG_WORD_COUNT:  d.rdData = q.wordCount;
        REG_LAST_ADDR:   d.rdData = {{(32-ADDR_W){1'b0}}, q.lastAddr};
        REG_LATCH_COUNT: d.rdData = q.latchCount;
        default:         d.rdData = 32'h0000_0000;
      endcase
    end else begin
      d.waitReq = 1'h1;
    end

    if (commit && avs_read && avs_address == REG_MEM_DATA) begin
      d.memAddr = q.memAddr + 1'b1;
    end

    if (commit && avs_write) begin
      unique case (avs_address)
        REG_CONFIG: begin
          // Ignored while the previous setting is still crossing
          if (!cfgPending) begin
            d.latency   = clampLatency(cfgMerged[CFG_LAT_MSB:CFG_LAT_LSB]);
            d.waitEarly = cfgMerged[CFG_WAIT_EARLY_BIT];
            d.falling   = cfgMerged[CFG_FALLING_BIT];
            d.waitFunc  = cfgMerged[CFG_WAIT_FUNC_BIT];
            d.cfgTgl    = !q.cfgTgl;
          end
        end
        REG_MEM_ADDR: begin
          d.memAddr = addrMerged[MEM_AW-1:0];
        end
        REG_MEM_DATA: begin
          d.memAddr = q.memAddr + 1'b1;
        end
        REG_WORD_COUNT: begin
          // A word arriving in the clearing cycle is still counted
          d.wordCount = wordEvent ? 32'h0000_0001 : 32'h0000_0000;
        end
        REG_LATCH_COUNT: begin
          d.latchCount = latchEvent ? 32'h0000_0001 : 32'h0000_0000;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      q <= '{waitReq: WAIT_REQ_RESET, rdData: 32'h0000_0000, latency: LATENCY_DEFAULT,
             waitEarly: WAIT_EARLY_DEFAULT, falling: FALLING_DEFAULT,
             waitFunc: WAIT_FUNC_DEFAULT, cfgTgl: 1'h0, ackSync: 2'h0, busySync: 2'h0,
             wordSync: 3'h0, latchSync: 3'h0, lastAddr: '0, memAddr: '0,
             wordCount: 32'h0000_0000, latchCount: 32'h0000_0000};
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Word array
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (memWe) begin
      mem[q.memAddr] <= memWrData;
    end
  end

  assign avs_readdata    = q.rdData;
  assign avs_waitrequest = q.waitReq;

endmodule

/* pkg/nor_burst_pkg.sv */
package nor_burst_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W_DEFAULT   = 16;
  localparam int MEM_AW_DEFAULT   = 8;
  localparam int WORD_W           = 16;
  localparam int BUS_AW           = 5;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [BUS_AW-1:0] REG_CONFIG     = 5'h00;
  localparam logic [BUS_AW-1:0] REG_STATUS     = 5'h04;
  localparam logic [BUS_AW-1:0] REG_MEM_ADDR   = 5'h08;
  localparam logic [BUS_AW-1:0] REG_MEM_DATA   = 5'h0C;
  localparam logic [BUS_AW-1:0] REG_WORD_COUNT = 5'h10;
  localparam logic [BUS_AW-1:0] REG_LAST_ADDR  = 5'h14;
  localparam logic [BUS_AW-1:0] REG_LATCH_COUNT = 5'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_LAT_LSB        = 0;
  localparam int CFG_LAT_MSB        = 2;
  localparam int CFG_WAIT_EARLY_BIT = 4;
  localparam int CFG_FALLING_BIT    = 5;
  localparam int CFG_WAIT_FUNC_BIT  = 6;
  localparam int STAT_CFG_PEND_BIT  = 0;
  localparam int STAT_BUSY_BIT      = 1;

  // ----------------------------------------------------------------
  // Values after reset, and the lowest latency accepted
  // ----------------------------------------------------------------
  localparam logic [2:0]  LATENCY_DEFAULT    = 3'h7;
  localparam logic [2:0]  LATENCY_MIN        = 3'h1;
  localparam logic        WAIT_EARLY_DEFAULT = 1'h0;
  localparam logic        FALLING_DEFAULT    = 1'h0;
  localparam logic        WAIT_FUNC_DEFAULT  = 1'h1;
  localparam logic        WAIT_REQ_RESET     = 1'h1;
  localparam logic        READY_IDLE_LEVEL   = 1'h1;

  // Fastest burst clock the far end may apply
  localparam int          BURST_CLK_MAX_MHZ  = 54;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [WORD_W-1:0] word_t;

  typedef enum logic [2:0] {
    LINK_IDLE    = 3'b001,
    LINK_LATENCY = 3'b010,
    LINK_DATA    = 3'b100
  } linkState_e;

endpackage

/* pkg/burst_link_if.sv */
`timescale 1ns/10ps
interface burst_link_if #(
  parameter int ADDR_W = 16,
  parameter int MEM_AW = 8
);
  // Configuration from the register side
  logic [2:0]        cfgLatency;
  logic              cfgWaitEarly;
  logic              cfgWaitFunc;
  logic              cfgTgl;
  logic              cfgAck;
  // Array read port
  logic [MEM_AW-1:0] rdAddr;
  logic [15:0]       rdData;
  // Link pins
  logic              latchN;
  logic              chipSelN;
  logic              outEnN;
  logic [ADDR_W-1:0] addrIn;
  logic [15:0]       dataOut;
  logic              dataOe;
  logic              rwOut;
  logic              rwOe;
  // Status back to the register side
  logic              wordTgl;
  logic              latchTgl;
  logic [ADDR_W-1:0] lastAddr;
  logic              busy;

  modport core (
    output cfgLatency, cfgWaitEarly, cfgWaitFunc, cfgTgl, rdData,
    output latchN, chipSelN, outEnN, addrIn,
    input  cfgAck, rdAddr, dataOut, dataOe, rwOut, rwOe,
    input  wordTgl, latchTgl, lastAddr, busy
  );

  modport engine (
    input  cfgLatency, cfgWaitEarly, cfgWaitFunc, cfgTgl, rdData,
    input  latchN, chipSelN, outEnN, addrIn,
    output cfgAck, rdAddr, dataOut, dataOe, rwOut, rwOe,
    output wordTgl, latchTgl, lastAddr, busy
  );
endinterface

/* core/burst_engine.sv */
`timescale 1ns/10ps
module burst_engine
  import nor_burst_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int MEM_AW = 8
) (
  // Link clock and reset request
  input  wire logic   linkClk,
  input  wire logic   rstReq,
  // Core side
  burst_link_if.engine link
);
  import nor_burst_pkg::*;

  typedef struct packed {
    linkState_e        state;
    logic [2:0]        cnt;
    logic [MEM_AW-1:0] addr;
    logic [15:0]       dataOut;
    logic              dataOe;
    logic              rwOut;
    logic              rwOe;
    logic              held;
    logic [2:0]        latency;
    logic              waitEarly;
    logic              waitFunc;
    logic [2:0]        cfgSync;
    logic              wordTgl;
    logic              latchTgl;
    logic [ADDR_W-1:0] lastAddr;
  } eng_s;

  eng_s       q;
  eng_s       d;
  logic [1:0] rstSync;

  // ----------------------------------------------------------------
  // Reset brought into the link domain
  // ----------------------------------------------------------------
  always_ff @(posedge linkClk) begin
    rstSync <= {rstSync[0], rstReq};
  end

  // ----------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d         = q;
    d.cfgSync = {q.cfgSync[1:0], link.cfgTgl};
    if (q.cfgSync[2] != q.cfgSync[1]) begin
      d.latency   = link.cfgLatency;
      d.waitEarly = link.cfgWaitEarly;
      d.waitFunc  = link.cfgWaitFunc;
    end
    if (link.chipSelN) begin
      d.state  = LINK_IDLE;
      d.dataOe = 1'h0;
      d.rwOut  = READY_IDLE_LEVEL;
      d.rwOe   = !q.waitFunc;
      d.held   = 1'h0;
    end else begin
      d.dataOe = !link.outEnN;
      d.rwOe   = !q.waitFunc || !link.outEnN;
      if (!link.latchN) begin
        d.addr     = link.addrIn[MEM_AW-1:0];
        d.lastAddr = link.addrIn;
        d.latchTgl = !q.latchTgl;
        d.cnt      = q.latency;
        d.state    = LINK_LATENCY;
        d.rwOut    = 1'h0;
        d.held     = 1'h0;
      end else begin
        unique case (q.state)
          LINK_IDLE: begin
            d.rwOut = READY_IDLE_LEVEL;
          end
          LINK_LATENCY: begin
            d.cnt = q.cnt - 3'h1;
            if (q.waitEarly && q.cnt == 3'h2) begin
              d.rwOut = 1'h1;
            end
            if (q.cnt == 3'h1) begin
              d.dataOut = link.rdData;
              d.addr    = q.addr + 1'b1;
              d.wordTgl = !q.wordTgl;
              d.rwOut   = 1'h1;
              d.state   = LINK_DATA;
            end
          end
          LINK_DATA: begin
            if (link.outEnN) begin
              d.held = 1'h1;
            end else if (q.held) begin
              d.held = 1'h0;
            end else begin
              d.dataOut = link.rdData;
              d.addr    = q.addr + 1'b1;
              d.wordTgl = !q.wordTgl;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge linkClk) begin
    if (rstSync[1]) begin
      q <= '{state: LINK_IDLE, cnt: 3'h0, addr: '0, dataOut: 16'h0000, dataOe: 1'h0,
             rwOut: READY_IDLE_LEVEL, rwOe: 1'h0, held: 1'h0, latency: LATENCY_DEFAULT,
             waitEarly: WAIT_EARLY_DEFAULT, waitFunc: WAIT_FUNC_DEFAULT, cfgSync: 3'h0,
             wordTgl: 1'h0, latchTgl: 1'h0, lastAddr: '0};
    end else begin
      q <= d;
    end
  end

  assign link.cfgAck   = q.cfgSync[2];
  assign link.rdAddr   = q.addr;
  assign link.dataOut  = q.dataOut;
  assign link.dataOe   = q.dataOe;
  assign link.rwOut    = q.rwOut;
  assign link.rwOe     = q.rwOe;
  assign link.wordTgl  = q.wordTgl;
  assign link.latchTgl = q.latchTgl;
  assign link.lastAddr = q.lastAddr;
  assign link.busy     = (q.state != LINK_IDLE);

endmodule

/* verif/burst_port_monitor.sv */
`timescale 1ns/10ps
module burst_port_monitor #(
  parameter int ADDR_W = 16
) (
  // System side
  input wire logic                             clk_sys,
  input wire logic                             sys_rst,
  input wire logic [nor_burst_pkg::BUS_AW-1:0] avs_address,
  input wire logic                             avs_read,
  input wire logic                             avs_write,
  input wire logic [31:0]                      avs_writedata,
  input wire logic [3:0]                       avs_byteenable,
  input wire logic [31:0]                      avs_readdata,
  input wire logic                             avs_waitrequest,
  // Link side
  input wire logic                             burstClk,
  input wire logic                             latchN,
  input wire logic                             chipSelN,
  input wire logic                             outEnN,
  input wire logic [ADDR_W-1:0]                addrIn,
  input wire logic [15:0]                      dataOut,
  input wire logic                             dataOe,
  input wire logic                             readyWaitOut,
  input wire logic                             readyWaitOe
);
  import nor_burst_pkg::*;
  logic [2:0] lat_q;
  logic       early_q;
  logic       fall_q;
  logic       func_q;
  logic [3:0] cnt_q;
  logic [3:0] effLat;

  // ------------------------
  // Config shadow, latency count
  // ------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lat_q   <= LATENCY_DEFAULT;
      early_q <= WAIT_EARLY_DEFAULT;
      fall_q  <= FALLING_DEFAULT;
      func_q  <= WAIT_FUNC_DEFAULT;
    end else if (avs_write && !avs_waitrequest && avs_address == REG_CONFIG) begin
      lat_q   <= avs_writedata[2:0];
      early_q <= avs_writedata[4];
      fall_q  <= avs_writedata[5];
      func_q  <= avs_writedata[6];
    end
  end

  assign effLat = ((lat_q == 3'h0) ? 4'h1 : {1'b0, lat_q})
                - ((early_q && lat_q > 3'h1) ? 4'h1 : 4'h0);

  always_ff @(posedge burstClk) begin
    if (sys_rst || chipSelN) cnt_q <= 4'h0;
    else if (!latchN) cnt_q <= 4'h1;
    else if (cnt_q != 4'h0 && cnt_q < 4'h8) cnt_q <= cnt_q + 4'h1;
  end

  chk_bus_answer: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  chk_bus_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_oe_on: assert property (
    @(posedge burstClk) disable iff (sys_rst || fall_q)
    !chipSelN && !outEnN |=> dataOe) else $error("data pins not driven");
  chk_oe_fall: assert property (
    @(negedge burstClk) disable iff (sys_rst || !fall_q)
    !chipSelN && !outEnN |=> dataOe) else $error("falling edge not active");
  chk_burst_end: assert property (
    @(posedge burstClk) disable iff (sys_rst || fall_q)
    chipSelN |=> !dataOe && readyWaitOut) else $error("burst not ended");
  chk_wait_float: assert property (
    @(posedge burstClk) disable iff (sys_rst || fall_q || !func_q)
    chipSelN |=> !readyWaitOe) else $error("ready pin not released");
  chk_latch_wait: assert property (
    @(posedge burstClk) disable iff (sys_rst || fall_q)
    !chipSelN && !latchN |=> !readyWaitOut) else $error("no wait after latch");
  chk_wait_low: assert property (
    @(posedge burstClk) disable iff (sys_rst || fall_q)
    !chipSelN && latchN && cnt_q != 4'h0 && cnt_q < effLat |=> !readyWaitOut)
    else $error("ready before latency expired");
  chk_first_word: assert property (
    @(posedge burstClk) disable iff (sys_rst || fall_q)
    !chipSelN && latchN && cnt_q == effLat |=> readyWaitOut)
    else $error("ready late after latency");
  chk_ready_keep: assert property (
    @(posedge burstClk) disable iff (sys_rst || fall_q)
    readyWaitOut && !chipSelN && latchN && !outEnN |=> readyWaitOut)
    else $error("ready dropped in data phase");
endmodule

/* verif/burst_host_model.sv */
`timescale 1ns/10ps
module burst_host_model #(
  parameter int ADDR_W = 16
) (
  // Pins toward the device
  output logic              burstClk,
  output logic              latchN,
  output logic              chipSelN,
  output logic              outEnN,
  output logic [ADDR_W-1:0] addrIn,
  // Pins from the device
  input  wire logic [15:0]  dataOut,
  input  wire logic         dataOe,
  input  wire logic         readyWaitOut,
  input  wire logic         readyWaitOe
);
  // Seen at the inactive edge after each active edge
  logic [15:0] sD;
  logic        sR;
  logic        sOe;
  logic        sRoe;

  initial begin
    burstClk = 1'b0;
    latchN   = 1'b1;
    chipSelN = 1'b1;
    outEnN   = 1'b1;
    addrIn   = '0;
  end

  // One 48 ns period; pins change mid phase at the idle level, clock idles between calls
  task automatic tick();
    #12;
    burstClk = ~burstClk;
    #24;
    sD = dataOe ? dataOut : ~dataOut;
    sR = readyWaitOut;
    sOe = dataOe;
    sRoe = readyWaitOe;
    burstClk = ~burstClk;
    #12;
  endtask

  task automatic idle(input int n);
    chipSelN = 1'b1;
    outEnN = 1'b1;
    latchN = 1'b1;
    repeat (n) tick();
  endtask

  // Latch edge, then the address lines stop carrying the start address
  task automatic start(input logic [ADDR_W-1:0] a);
    chipSelN = 1'b0;
    outEnN = 1'b0;
    latchN = 1'b0;
    addrIn = a;
    tick();
    latchN = 1'b1;
    addrIn = ~a;
  endtask
endmodule

/* verif/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import nor_burst_pkg::*;
  logic              clk_sys;
  logic              sys_rst;
  logic [BUS_AW-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              burstClk;
  logic              latchN;
  logic              chipSelN;
  logic              outEnN;
  logic [15:0]       addrIn;
  logic [15:0]       dataOut;
  logic              dataOe;
  logic              readyWaitOut;
  logic              readyWaitOe;
  logic [31:0]       rd;
  int                nMismatch = 0;
  int                checks = 0;
  int                cycles = 0;

  nor_sync_burst_read_port dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .burstClk(burstClk), .latchN(latchN),
    .chipSelN(chipSelN), .outEnN(outEnN), .addrIn(addrIn), .dataOut(dataOut),
    .dataOe(dataOe), .readyWaitOut(readyWaitOut), .readyWaitOe(readyWaitOe));

  burst_host_model host (.burstClk(burstClk), .latchN(latchN), .chipSelN(chipSelN),
    .outEnN(outEnN), .addrIn(addrIn), .dataOut(dataOut), .dataOe(dataOe),
    .readyWaitOut(readyWaitOut), .readyWaitOe(readyWaitOe));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 40000) begin
      nMismatch++;
      test_done();
    end
  end

  function automatic word_t memVal(input int i);
    return {i[7:0], ~i[7:0]};
  endfunction

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [BUS_AW-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Link clocks idle so the setting can cross, then pending must clear
  task automatic cfg(input logic [31:0] v);
    int n = 0;
    bus(1'b1, REG_CONFIG, v);
    do begin
      host.idle(2);
      bus(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rd[STAT_CFG_PEND_BIT] !== 1'b0 && n < 20);
    check(rd[STAT_CFG_PEND_BIT], 32'h0);
  endtask

  task automatic burst(input int a, input int lat, input int early, input int words);
    host.start(a[15:0]);
    for (int k = 1; k <= lat; k++) begin
      host.tick();
      check(host.sR, (k >= lat - early) ? 1 : 0);
    end
    check(host.sD, memVal(a));
    check({host.sOe, host.sRoe}, 32'h3);
    for (int k = 1; k < words; k++) begin
      host.tick();
      check(host.sD, memVal(a + k));
    end
  endtask

  task automatic finish_burst(input logic func = 1'b1);
    host.idle(1);
    check({host.sOe, host.sRoe, host.sR}, {30'h0, !func, 1'b1});
  endtask

  task automatic run(input logic [31:0] v, input int a, input int lat, input int e, input int n);
    cfg(v);
    burst(a, lat, e, n);
    finish_burst(v[CFG_WAIT_FUNC_BIT]);
  endtask

  // ------------------------
  // Scenarios
  // ------------------------
  task automatic t_fill();
    bus(1'b1, REG_MEM_ADDR, 32'h0);
    for (int i = 0; i < 256; i++) bus(1'b1, REG_MEM_DATA, {16'h0, memVal(i)});
    bus(1'b1, REG_MEM_ADDR, 32'h5);
    bus(1'b0, REG_MEM_DATA, 32'h0);
    check(rd, {16'h0, memVal(5)});
    bus(1'b0, 5'h1C, 32'h0);
    check(rd, 32'h0);
  endtask

  task automatic t_default();
    burst(3, 7, 0, 4);
    finish_burst();
    bus(1'b0, REG_LAST_ADDR, 32'h0);
    check(rd, 32'h3);
    bus(1'b0, REG_WORD_COUNT, 32'h0);
    check(rd, 32'h4);
    bus(1'b0, REG_LATCH_COUNT, 32'h0);
    check(rd, 32'h1);
  endtask

  task automatic t_suspend();
    word_t w;
    burst(40, 5, 0, 2);
    repeat (20) @(posedge clk_sys);
    host.tick();
    check(host.sD, memVal(42));
    host.outEnN = 1'b1;
    host.tick();
    host.tick();
    check(host.sOe, 32'h0);
    host.outEnN = 1'b0;
    host.tick();
    check(host.sR, 32'h1);
    w = host.sD;
    check(w, memVal(42));
    host.tick();
    check(host.sD, memVal(43));
    finish_burst();
  endtask

  task automatic t_falling();
    host.burstClk = 1'b1;
    run(32'h67, 60, 7, 0, 3);
  endtask

  initial begin
    sys_rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    fork
      repeat (20) @(posedge clk_sys);
      begin
        @(posedge clk_sys);
        host.idle(12);
      end
    join
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    host.idle(4);
    t_fill();
    t_default();
    run(32'h52, 254, 2, 1, 4);
    run(32'h40, 10, 1, 0, 2);
    run(32'h45, 20, 5, 0, 3);
    t_suspend();
    run(32'h06, 100, 6, 0, 2);
    t_falling();
    test_done();
  end
endmodule

bind nor_sync_burst_read_port burst_port_monitor #(.ADDR_W(ADDR_W)) mon (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .burstClk(burstClk),
  .latchN(latchN), .chipSelN(chipSelN), .outEnN(outEnN), .addrIn(addrIn),
  .dataOut(dataOut), .dataOe(dataOe), .readyWaitOut(readyWaitOut),
  .readyWaitOe(readyWaitOe));
